/* File: design/vyc_pkg.sv */
// vyc_pkg: shared constants and carriers of the yuv capture block.
// assumes one 32-bit word memory port and a ccir656 byte stream.
package vyc_pkg;

	localparam int NPLANE = 3;
	localparam int PL_Y = 0;
	localparam int COORD_W = 12;
	localparam int EV_DONE = 0;
	localparam int EV_THR = 1;
	localparam int EV_HBE = 2;
	localparam int CLOSE_CYC = 4;

	// base addresses hold 64-byte alignment
	localparam logic [31:0] BASE_ALIGN_MASK = 32'hffff_ffc0;
	localparam logic [7:0] CODE_PRE_FF = 8'hff;
	localparam logic [7:0] CODE_PRE_00 = 8'h00;
	localparam int XY_F = 6;
	localparam int XY_V = 5;
	localparam int XY_H = 4;
	localparam logic [7:0] SAT_LO = 8'h01;
	localparam logic [7:0] SAT_HI = 8'hff;

	typedef enum logic [1:0] {
		TK_NONE = 2'h0,
		TK_BYTE = 2'h1,
		TK_SAV  = 2'h2,
		TK_EAV  = 2'h3
	} vyc_tok_e;

	typedef struct packed {
		vyc_tok_e   kind;
		logic       fld;
		logic       vbl;
		logic [7:0] data;
	} vyc_tok_s;

	typedef struct packed {
		logic signed [5:0] c0;
		logic signed [5:0] c1;
		logic signed [5:0] c2;
		logic signed [5:0] c3;
		logic [2:0]        shift;
		logic              bypass;
	} vyc_coef_s;

	localparam vyc_coef_s COEF_PASS = '{6'sh00, 6'sh10, 6'sh00, 6'sh00, 3'h4, 1'b1};
	localparam vyc_coef_s COEF_HALF = '{6'sh01, 6'sh02, 6'sh01, 6'sh00, 3'h2, 1'b0};
	localparam vyc_coef_s COEF_INTER = '{6'sh3f, 6'sh0d, 6'sh05, 6'sh3f, 3'h4, 1'b0};

	typedef struct packed {
		logic                          enable;
		logic                          halfRes;
		logic                          samplingConventionBit;
		logic                          littleEndian;
		logic [2:0]                    irqEnable;
		logic [2:0]                    ack;
		logic [COORD_W-1:0]            startX;
		logic [COORD_W-1:0]            startY;
		logic [COORD_W-1:0]            width;
		logic [COORD_W-1:0]            height;
		logic [COORD_W-1:0]            threshold;
		logic [NPLANE-1:0][31:0]       base;
		logic [NPLANE-1:0][15:0]       stride;
	} vyc_ctl_s;

	typedef struct packed {
		logic [2:0]         flags;
		logic               secondFieldFlag;
		logic [COORD_W-1:0] curX;
		logic [COORD_W-1:0] currentLineCount;
	} vyc_stat_s;

	typedef struct packed {
		logic        valid;
		logic [31:0] addr;
		logic [31:0] data;
		logic [3:0]  be;
	} vyc_mem_s;

endpackage

/* File: design/vyc_code_decoder.sv */
// vyc_code_decoder: link-side parser of the ccir656 byte stream.
// runs on the source's pixel clock; emits one token per change of tokTgl.
`timescale 1ns/10ps
module vyc_code_decoder
	import vyc_pkg::*;
(
	input  wire logic       clk_vid,
	input  wire logic       arst_n,
	input  wire logic [7:0] vidData,
	input  wire logic       vidValid,
	output vyc_tok_s        tok,
	output logic            tokTgl
);

	logic [1:0] preCnt_q;
	logic [3:0] syn;
	logic       dbl;
	logic       fixF;
	logic       fixV;
	logic       fixH;

	// hamming syndrome of the xy byte
	always_comb begin
		syn[3] = vidData[3] ^ vidData[XY_V] ^ vidData[XY_H];
		syn[2] = vidData[2] ^ vidData[XY_F] ^ vidData[XY_H];
		syn[1] = vidData[1] ^ vidData[XY_F] ^ vidData[XY_V];
		syn[0] = vidData[0] ^ vidData[XY_F] ^ vidData[XY_V] ^ vidData[XY_H];
		dbl = (syn == 4'hf) || ($countones(syn) == 2);
		fixF = vidData[XY_F] ^ (syn == 4'h7);
		fixV = vidData[XY_V] ^ (syn == 4'hb);
		fixH = vidData[XY_H] ^ (syn == 4'hd);
	end

	// preamble tracking and token output; data held until the next byte
	always_ff @(posedge clk_vid or negedge arst_n) begin
		if (!arst_n) begin
			preCnt_q <= 2'h0;
			tok <= '0;
			tokTgl <= 1'b0;
		end else if (vidValid) begin
			if (preCnt_q == 2'h3) begin
				preCnt_q <= 2'h0;
				if (!(dbl && !vidData[XY_H])) begin
					tok.fld <= fixF;
					tok.vbl <= fixV;
					tok.data <= vidData;
					tok.kind <= (dbl || fixH) ? TK_EAV : TK_SAV;
					tokTgl <= ~tokTgl;
				end
			end else if (vidData == CODE_PRE_FF) begin
				preCnt_q <= 2'h1;
			end else if (vidData == CODE_PRE_00 && preCnt_q != 2'h0) begin
				preCnt_q <= preCnt_q + 2'h1;
			end else begin
				preCnt_q <= 2'h0;
				// reserved values never carry samples
				if (vidData != CODE_PRE_00) begin
					tok.kind <= TK_BYTE;
					tok.data <= vidData;
					tokTgl <= ~tokTgl;
				end
			end
		end
	end

endmodule

/* File: design/vyc_fir.sv */
// vyc_fir: four-tap line filter with edge mirroring and saturation.
// expects lineStart with the first sample and one flush pulse per segment.
`timescale 1ns/10ps
module vyc_fir
	import vyc_pkg::*;
(
	input  wire logic       clk_sys,
	input  wire logic       arst_n,
	input  wire vyc_coef_s  coef,
	input  wire logic       inValid,
	input  wire logic       lineStart,
	input  wire logic [7:0] inData,
	input  wire logic       flush,
	output logic            outValid,
	output logic [7:0]      outData
);

	logic [7:0]         a_q;
	logic [7:0]         b_q;
	logic [7:0]         c_q;
	logic [1:0]         cnt_q;
	logic [1:0]         flushSt_q;
	logic [3:0][7:0]    w;
	logic signed [15:0] sum;
	logic signed [15:0] res;
	logic [7:0]         sat;

	always_comb begin
		if (flushSt_q == 2'h1)
			w = {a_q, b_q, c_q, b_q};
		else if (flushSt_q == 2'h2)
			w = {b_q, c_q, b_q, a_q};
		else
			w = {a_q, b_q, c_q, inData};
		sum = 16'(coef.c0 * $signed({1'b0, w[3]})) + 16'(coef.c1 * $signed({1'b0, w[2]}))
			+ 16'(coef.c2 * $signed({1'b0, w[1]})) + 16'(coef.c3 * $signed({1'b0, w[0]}));
		res = sum >>> coef.shift;
		if (coef.bypass)
			sat = w[2];
		else if (res < $signed({8'h00, SAT_LO}))
			sat = SAT_LO;
		else if (res > $signed({8'h00, SAT_HI}))
			sat = SAT_HI;
		else
			sat = res[7:0];
	end

	// window shift; output lags input by two samples, flush emits the tail
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			a_q <= 8'h00;
			b_q <= 8'h00;
			c_q <= 8'h00;
			cnt_q <= 2'h0;
			flushSt_q <= 2'h0;
			outValid <= 1'b0;
			outData <= 8'h00;
		end else begin
			outValid <= 1'b0;
			if (flushSt_q != 2'h0) begin
				outValid <= 1'b1;
				outData <= sat;
				flushSt_q <= (flushSt_q == 2'h1) ? 2'h2 : 2'h0;
				if (flushSt_q == 2'h2)
					cnt_q <= 2'h0;
			end else if (flush) begin
				if (cnt_q == 2'h2)
					flushSt_q <= 2'h1;
				else
					cnt_q <= 2'h0;
			end else if (inValid) begin
				if (lineStart || cnt_q == 2'h0) begin
					c_q <= inData;
					cnt_q <= 2'h1;
				end else if (cnt_q == 2'h1) begin
					a_q <= inData;
					b_q <= c_q;
					c_q <= inData;
					cnt_q <= 2'h2;
				end else begin
					a_q <= b_q;
					b_q <= c_q;
					c_q <= inData;
					outValid <= 1'b1;
					outData <= sat;
				end
			end
		end
	end

endmodule

/* File: design/vyc_capture_top.sv */
// vyc_capture_top: yuv planar capture of a ccir656 stream into memory.
// assumes a word memory port with valid/ready and control as plain ports;
// ack bits are one-cycle pulses from the control word write.
`timescale 1ns/10ps
module vyc_capture_top
	import vyc_pkg::*;
(
	input  wire logic       clk_sys,
	input  wire logic       arst_n,
	input  wire logic       clk_vid,
	input  wire logic [7:0] vidData,
	input  wire logic       vidValid,
	input  wire vyc_ctl_s   ctl,
	output vyc_stat_s       stat,
	output logic            irq,
	output vyc_mem_s        mem,
	input  wire logic       memReady
);

	typedef enum logic [3:0] {
		ST_IDLE  = 4'b0001,
		ST_ARMED = 4'b0010,
		ST_CAPT  = 4'b0100,
		ST_DRAIN = 4'b1000
	} vyc_state_e;

	vyc_state_e         state_q;
	vyc_tok_s           tok;
	logic               tokTgl;
	logic [2:0]         tglSync_q;
	logic               tglSeen_q;
	logic               tokEv;
	logic               isSav;
	logic               isEav;
	logic               isByte;
	logic [1:0]         byteIdx_q;
	logic [COORD_W-1:0] yCnt_q;
	logic [COORD_W-1:0] curX_q;
	logic [COORD_W-1:0] curY_q;
	logic [COORD_W-1:0] curYNext;
	logic               vPrev_q;
	logic               second_field_flag_q;
	logic               lineOn_q;
	logic [COORD_W:0]   lineBytes_q;
	logic [COORD_W-1:0] linesDone_q;
	logic [2:0]         segStart_q;
	logic               flush;
	logic               lineClose_q;
	logic [2:0]         closeCnt_q;
	logic               lineEnd;
	logic               capStart;
	logic               lineGo;
	logic [2:0]         flags_q;
	logic [2:0]         flagsSet;
	logic [2:0]         flagsNext;
	logic [2:0]         inVal;
	logic [2:0]         keep;
	logic [2:0]         phase_q;
	logic [2:0]         firVal;
	logic [7:0]         firData [NPLANE];
	logic [2:0]         pend;
	logic [2:0]         grant;
	logic [2:0]         drop;
	logic               memFree;
	logic               idle;
	vyc_coef_s          lumaCoef;
	vyc_coef_s          chromaCoef;
	logic [31:0]        pendAddr [NPLANE];
	logic [31:0]        pendData [NPLANE];
	logic [3:0]         pendBe [NPLANE];

	// link-side code parser on the source clock
	vyc_code_decoder u_dec (
		.clk_vid  (clk_vid),
		.arst_n   (arst_n),
		.vidData  (vidData),
		.vidValid (vidValid),
		.tok      (tok),
		.tokTgl   (tokTgl)
	);

	// toggle crossing: tok is held a full link period, read once stage two and three agree
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			tglSync_q <= 3'h0;
			tglSeen_q <= 1'b0;
		end else begin
			tglSync_q <= {tglSync_q[1:0], tokTgl};
			if (tokEv)
				tglSeen_q <= tglSync_q[2];
		end
	end

	assign tokEv = (tglSync_q[1] == tglSync_q[2]) && (tglSync_q[2] != tglSeen_q);
	assign isSav = tokEv && tok.kind == TK_SAV;
	assign isEav = tokEv && tok.kind == TK_EAV;
	assign isByte = tokEv && tok.kind == TK_BYTE;

	always_comb begin
		if (vPrev_q && !tok.vbl)
			curYNext = '0;
		else
			curYNext = curY_q + 1'b1;
	end

	// stream position: byte phase in u y v y, luma column, line and field
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			byteIdx_q <= 2'h0;
			yCnt_q <= '0;
			curX_q <= '0;
			curY_q <= '0;
			vPrev_q <= 1'b0;
			second_field_flag_q <= 1'b0;
		end else if (isSav) begin
			byteIdx_q <= 2'h0;
			yCnt_q <= '0;
			curY_q <= curYNext;
			vPrev_q <= tok.vbl;
			second_field_flag_q <= tok.fld;
		end else if (isByte) begin
			byteIdx_q <= byteIdx_q + 2'h1;
			if (byteIdx_q[0]) begin
				curX_q <= yCnt_q;
				yCnt_q <= yCnt_q + 1'b1;
			end
		end
	end

	assign capStart = state_q == ST_ARMED && isSav && curYNext == ctl.startY;
	assign lineGo = state_q == ST_CAPT && isByte && !lineOn_q && !lineClose_q
		&& byteIdx_q == 2'h0 && yCnt_q == ctl.startX && linesDone_q != ctl.height;
	assign idle = pend == 3'h0 && !mem.valid;

	// capture sequencing
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			state_q <= ST_IDLE;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (ctl.enable && !flags_q[EV_DONE])
						state_q <= ST_ARMED;
				end
				ST_ARMED: begin
					if (!ctl.enable)
						state_q <= ST_IDLE;
					else if (capStart)
						state_q <= ST_CAPT;
				end
				ST_CAPT: begin
					if (linesDone_q == ctl.height && !lineOn_q && !lineClose_q)
						state_q <= ST_DRAIN;
				end
				ST_DRAIN: begin
					if (idle)
						state_q <= ST_IDLE;
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// line window: 2*width bytes from the start column, eav or not
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			lineOn_q <= 1'b0;
			lineBytes_q <= '0;
			linesDone_q <= '0;
			segStart_q <= 3'h0;
			lineClose_q <= 1'b0;
			closeCnt_q <= 3'h0;
		end else begin
			if (capStart)
				linesDone_q <= '0;
			if (lineGo) begin
				lineOn_q <= 1'b1;
				lineBytes_q <= {{COORD_W{1'b0}}, 1'b1};
				segStart_q <= 3'b101; // u already restarts through lineGo
			end else if (lineOn_q && isByte) begin
				lineBytes_q <= lineBytes_q + 1'b1;
				segStart_q <= segStart_q & ~inVal;
			end
			if (lineOn_q && isEav)
				segStart_q <= 3'b111;
			if (lineOn_q && lineBytes_q == {ctl.width, 1'b0}) begin
				lineOn_q <= 1'b0;
				lineClose_q <= 1'b1;
				closeCnt_q <= 3'(CLOSE_CYC);
			end else if (lineClose_q) begin
				closeCnt_q <= closeCnt_q - 3'h1;
				if (closeCnt_q == 3'h1) begin
					lineClose_q <= 1'b0;
					linesDone_q <= linesDone_q + 1'b1;
				end
			end
		end
	end

	assign flush = (lineOn_q && isEav) || (lineOn_q && lineBytes_q == {ctl.width, 1'b0});
	assign lineEnd = lineClose_q && closeCnt_q == 3'h1;

	// steer bytes to planes: u at phase 0, y at 1 and 3, v at 2
	always_comb begin
		inVal = 3'h0;
		if (isByte && (lineOn_q || lineGo)) begin
			if (byteIdx_q[0])
				inVal[PL_Y] = 1'b1;
			else if (byteIdx_q[1])
				inVal[2] = 1'b1;
			else
				inVal[1] = 1'b1;
		end
	end

	always_comb begin
		lumaCoef = ctl.halfRes ? COEF_HALF : COEF_PASS;
		if (ctl.samplingConventionBit)
			chromaCoef = COEF_INTER;
		else if (ctl.halfRes)
			chromaCoef = COEF_HALF;
		else
			chromaCoef = COEF_PASS;
	end

	assign memFree = !mem.valid || memReady;

	// fixed priority luma first; one word per plane at most waits
	always_comb begin
		grant = 3'h0;
		if (memFree) begin
			if (pend[0])
				grant = 3'b001;
			else if (pend[1])
				grant = 3'b010;
			else if (pend[2])
				grant = 3'b100;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < NPLANE; gi++) begin : g_plane
			logic [31:0] ptr_q;
			logic [31:0] lineBase_q;
			logic [31:0] word_q;
			logic [3:0]  be_q;
			logic        pend_q;
			logic [31:0] pAddr_q;
			logic [31:0] pData_q;
			logic [3:0]  pBe_q;
			logic [1:0]  lane;
			logic        emit;
			logic [31:0] wordNext;
			logic [3:0]  beNext;
			logic [31:0] nextLine;

			vyc_fir u_fir (
				.clk_sys   (clk_sys),
				.arst_n    (arst_n),
				.coef      ((gi == PL_Y) ? lumaCoef : chromaCoef),
				.inValid   (inVal[gi]),
				.lineStart (segStart_q[gi] || lineGo),
				.inData    (tok.data),
				.flush     (flush),
				.outValid  (firVal[gi]),
				.outData   (firData[gi])
			);

			always_ff @(posedge clk_sys or negedge arst_n) begin
				if (!arst_n)
					phase_q[gi] <= 1'b0;
				else if (lineGo)
					phase_q[gi] <= 1'b0;
				else if (firVal[gi])
					phase_q[gi] <= ~phase_q[gi];
			end

			assign keep[gi] = firVal[gi] && (!ctl.halfRes || !phase_q[gi]);
			assign lane = ctl.littleEndian ? ptr_q[1:0] : 2'h3 - ptr_q[1:0];
			assign nextLine = lineBase_q + {16'h0000, ctl.stride[gi]};

			// place sample in its byte lane
			always_comb begin
				wordNext = word_q;
				beNext = be_q;
				if (keep[gi]) begin
					wordNext[8 * lane +: 8] = firData[gi];
					beNext[lane] = 1'b1;
				end
			end

			assign emit = (keep[gi] && ptr_q[1:0] == 2'h3) || (lineEnd && be_q != 4'h0);

			// running pointer and word packer
			always_ff @(posedge clk_sys or negedge arst_n) begin
				if (!arst_n) begin
					ptr_q <= 32'h0;
					lineBase_q <= 32'h0;
					word_q <= 32'h0;
					be_q <= 4'h0;
				end else if (capStart) begin
					ptr_q <= ctl.base[gi] & BASE_ALIGN_MASK;
					lineBase_q <= ctl.base[gi] & BASE_ALIGN_MASK;
					word_q <= 32'h0;
					be_q <= 4'h0;
				end else if (lineEnd) begin
					ptr_q <= nextLine;
					lineBase_q <= nextLine;
					word_q <= 32'h0;
					be_q <= 4'h0;
				end else if (keep[gi]) begin
					ptr_q <= ptr_q + 32'h1;
					word_q <= emit ? 32'h0 : wordNext;
					be_q <= emit ? 4'h0 : beNext;
				end
			end

			assign drop[gi] = emit && pend_q && !grant[gi];

			always_ff @(posedge clk_sys or negedge arst_n) begin
				if (!arst_n) begin
					pend_q <= 1'b0;
					pAddr_q <= 32'h0;
					pData_q <= 32'h0;
					pBe_q <= 4'h0;
				end else if (emit && !drop[gi]) begin
					pend_q <= 1'b1;
					pAddr_q <= {ptr_q[31:2], 2'h0};
					pData_q <= lineEnd ? word_q : wordNext;
					pBe_q <= lineEnd ? be_q : beNext;
				end else if (grant[gi]) begin
					pend_q <= 1'b0;
				end
			end

			assign pend[gi] = pend_q;
			assign pendAddr[gi] = pAddr_q;
			assign pendData[gi] = pData_q;
			assign pendBe[gi] = pBe_q;
		end
	endgenerate

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			mem <= '0;
		end else if (memFree) begin
			mem.valid <= grant != 3'h0;
			for (int i = 0; i < NPLANE; i++) begin
				if (grant[i]) begin
					mem.addr <= pendAddr[i];
					mem.data <= pendData[i];
					mem.be <= pendBe[i];
				end
			end
		end
	end

	// event sources; set beats a same-cycle acknowledge
	always_comb begin
		flagsSet = 3'h0;
		flagsSet[EV_DONE] = state_q == ST_DRAIN && idle;
		flagsSet[EV_THR] = isSav && curYNext == ctl.threshold;
		flagsSet[EV_HBE] = drop != 3'h0;
		flagsNext = (flags_q & ~ctl.ack) | flagsSet;
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			flags_q <= 3'h0;
			irq <= 1'b0;
		end else begin
			flags_q <= flagsNext;
			irq <= (flagsNext & ctl.irqEnable) != 3'h0;
		end
	end

	assign stat = {flags_q, second_field_flag_q, curX_q, curY_q};

endmodule

/* File: verif/vyc_capture_properties.sv */
// vyc_capture_properties: port-level checks of the yuv capture top.
// assumes it is bound to vyc_capture_top; system clock domain only.
`timescale 1ns/10ps
module vyc_capture_properties
	import vyc_pkg::*;
(
	input wire logic       clk_sys,
	input wire logic       arst_n,
	input wire logic       clk_vid,
	input wire logic [7:0] vidData,
	input wire logic       vidValid,
	input wire vyc_ctl_s   ctl,
	input wire vyc_stat_s  stat,
	input wire logic       irq,
	input wire vyc_mem_s   mem,
	input wire logic       memReady
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!arst_n);

	irq_level_a:
	assert property (irq == |(stat.flags & $past(ctl.irqEnable))) else $error("irq does not follow flags");
	word_hold_a:
	assert property (mem.valid && !memReady |=> mem.valid && $stable(mem)) else $error("word moved before take");
	word_align_a:
	assert property (mem.valid |-> mem.addr[1:0] == 2'h0 && mem.be != 4'h0) else $error("bad word address");
	err_sticky_a:
	assert property (stat.flags[2] && !ctl.ack[2] |=> stat.flags[2]) else $error("error flag lost");
	done_ack_a:
	assert property (stat.flags[0] && ctl.ack[0] |=> !stat.flags[0]) else $error("complete not cleared");
	done_hold_a:
	assert property (stat.flags[0] && !ctl.ack[0] |=> stat.flags[0]) else $error("complete dropped");
	done_drained_a:
	assert property ($rose(stat.flags[0]) |-> !mem.valid) else $error("complete with word pending");
	line_step_a:
	assert property ($changed(stat.currentLineCount) |-> stat.currentLineCount == 12'h0 ||
		stat.currentLineCount - $past(stat.currentLineCount) == 12'h1) else $error("line count jump");
	thr_set_a:
	assert property ($changed(stat.currentLineCount) && stat.currentLineCount == ctl.threshold
		|-> ##[0:2] stat.flags[1]) else $error("threshold flag missing");
	thr_cause_a:
	assert property ($rose(stat.flags[1]) |-> ##[0:2] stat.currentLineCount == ctl.threshold)
		else $error("threshold flag without match");

	// main scenarios reached
	cover property ($rose(irq));
	cover property (mem.valid && !memReady);
	cover property ($rose(stat.flags[2]));
endmodule

bind vyc_capture_top vyc_capture_properties i_vyc_capture_properties (
	.clk_sys(clk_sys), .arst_n(arst_n), .clk_vid(clk_vid), .vidData(vidData), .vidValid(vidValid),
	.ctl(ctl), .stat(stat), .irq(irq), .mem(mem), .memReady(memReady)
);

/* File: verif/vyc_video_src.sv */
// vyc_video_src: ccir656 source model driving the link pins.
// each line ends with six idle link clocks; the link clock runs only while it sends.
`timescale 1ns/10ps
module vyc_video_src (
	output logic       clk_vid,
	output logic [7:0] vidData,
	output logic       vidValid
);
	// link starts still with no valid byte
	initial begin
		clk_vid = 1'b0;
		vidData = 8'h5a;
		vidValid = 1'b0;
	end

	// one byte per link clock, set half a period before the rising edge
	task automatic put(input logic [7:0] b, input logic v);
		vidData = b;
		vidValid = v;
		#24 clk_vid = 1'b1;
		#24 clk_vid = 1'b0;
	endtask

	// clock without data; the byte toggles so no stale value lingers
	task automatic idle(input int n);
		repeat (n) put(~vidData, 1'b0);
	endtask

	// timing code: fixed msb, field, blanking, h, then four protection bits
	function automatic logic [7:0] xy(input logic f, input logic v, input logic h);
		return {1'b1, f, v, h, v ^ h, f ^ h, f ^ v, f ^ v ^ h};
	endfunction

	// start code (err flips its bits), 16 bytes counting up, end code
	task automatic line(input logic f, input logic v, input logic [7:0] b, input logic [7:0] err);
		put(8'hff, 1'b1);
		put(8'h00, 1'b1);
		put(8'h00, 1'b1);
		put(xy(f, v, 1'b0) ^ err, 1'b1);
		for (int i = 0; i < 16; i++) begin
			put(b + 8'(i), 1'b1);
		end
		put(8'hff, 1'b1);
		put(8'h00, 1'b1);
		put(8'h00, 1'b1);
		put(xy(f, v, 1'b1), 1'b1);
		idle(6);
	endtask
endmodule

/* File: verif/tb_top.sv */
// tb_top: capture bench with a video source model and a memory sink.
// assumes the source model owns the link clock and stops it between frames.
`timescale 1ns/10ps
module tb_top
	import vyc_pkg::*;
;
	logic        clk_sys;
	logic        arst_n;
	logic        clk_vid;
	logic [7:0]  vidData;
	logic        vidValid;
	vyc_ctl_s    ctl;
	vyc_stat_s   stat;
	logic        irq;
	vyc_mem_s    mem;
	logic        memReady = 1'b0;
	logic        stall = 1'b0;
	logic [31:0] got [logic [31:0]];
	int          nWords = 0;
	int          cyc = 0;
	int          failures = 0;
	int          nTests = 0;

	vyc_capture_top i_vyc_capture_top (.clk_sys(clk_sys), .arst_n(arst_n), .clk_vid(clk_vid),
		.vidData(vidData), .vidValid(vidValid), .ctl(ctl), .stat(stat), .irq(irq), .mem(mem),
		.memReady(memReady));
	vyc_video_src i_vyc_video_src (.clk_vid(clk_vid), .vidData(vidData), .vidValid(vidValid));

	// 250 MHz system clock
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end

	// sink stalls one cycle in eight, or fully when asked; hang limit
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		memReady <= !stall && cyc[2:0] != 3'h0;
		if (mem.valid === 1'b1 && memReady === 1'b1) begin
			got[mem.addr] = mem.data;
			nWords++;
		end
		if (cyc == 20000) begin
			failures++;
			close_out();
		end
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
		nTests++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic close_out();
		$display("checks %0d mismatches %0d", nTests, failures);
		if (failures == 0 && nTests > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// byte i of active line n, kept clear of the code values 00 and ff
	function automatic logic [7:0] pv(input int n, input int i);
		return 8'h10 + 8'(n * 32 + i);
	endfunction

	// one blanking line, then n active lines counted from zero
	task automatic frame(input int n, input logic f);
		i_vyc_video_src.line(f, 1'b1, 8'h10, 8'h00);
		for (int k = 0; k < n; k++) begin
			i_vyc_video_src.line(f, 1'b0, pv(k, 0), 8'h00);
		end
		repeat (20) @(posedge clk_sys);
		#1;
	endtask

	task automatic ack(input logic [2:0] a);
		@(posedge clk_sys);
		ctl.ack <= a;
		@(posedge clk_sys);
		ctl.ack <= 3'h0;
		@(posedge clk_sys);
		#1;
	endtask

	task automatic wait_done();
		for (int k = 0; k < 3000 && stat.flags[0] !== 1'b1; k++) begin
			@(posedge clk_sys);
		end
		#1;
	endtask

	// captured lines are frame lines 1 and 2; eight luma, four chroma each
	task automatic check_img(input logic le, input logic [31:0] yb);
		logic [31:0] a;
		logic [31:0] d;
		logic [7:0]  s [4];
		for (int l = 0; l < 2; l++) begin
			for (int p = 0; p < 3; p++) begin
				for (int w = 0; w < (p == 0 ? 2 : 1); w++) begin
					for (int j = 0; j < 4; j++) begin
						s[j] = p == 0 ? pv(l + 1, 8 * w + 2 * j + 1) : pv(l + 1, 4 * j + 2 * p - 2);
					end
					d = le ? {s[3], s[2], s[1], s[0]} : {s[0], s[1], s[2], s[3]};
					a = (p == 0 ? yb : ctl.base[p]) + l * ctl.stride[p] + 4 * w;
					chk("word data", d, got[a]);
				end
			end
		end
		chk("word count", 8, nWords);
	endtask

	initial begin
		arst_n = 1'b0;
		ctl = '0;
		ctl.width = 12'h008;
		ctl.height = 12'h002;
		ctl.startY = 12'h001;
		ctl.threshold = 12'h002;
		ctl.irqEnable = 3'b101;
		ctl.base[0] = 32'h1000_0012;
		ctl.base[1] = 32'h0000_2000;
		ctl.base[2] = 32'h0000_3000;
		ctl.stride[0] = 16'h0100;
		ctl.stride[1] = 16'h0080;
		ctl.stride[2] = 16'h0080;
		// link edges must also pass during reset
		i_vyc_video_src.idle(2);
		repeat (5) @(posedge clk_sys);
		arst_n <= 1'b1;
		// capture off: threshold still fires, nothing is stored
		frame(4, 1'b1);
		chk("line count", 12'h003, stat.currentLineCount);
		chk("thr flag", 1, stat.flags[1]);
		chk("irq masked", 0, irq);
		chk("no writes", 0, nWords);
		chk("column", 12'h007, stat.curX);
		chk("field", 1, stat.secondFieldFlag);
		i_vyc_video_src.line(1'b1, 1'b0, 8'h40, 8'h40);
		i_vyc_video_src.line(1'b1, 1'b0, 8'h40, 8'h03);
		repeat (20) @(posedge clk_sys);
		#1;
		chk("corrected count", 12'h004, stat.currentLineCount);
		ack(3'b010);
		chk("thr ack", 0, stat.flags[1]);
		// first capture, big-endian, unaligned luma base
		ctl.enable <= 1'b1;
		frame(4, 1'b0);
		wait_done();
		check_img(1'b0, 32'h1000_0000);
		chk("flags", 3'b011, stat.flags);
		chk("irq", 1, irq);
		chk("field", 0, stat.secondFieldFlag);
		// acknowledge re-arms; new base and little-endian packing
		ack(3'b011);
		chk("irq drop", 0, irq);
		got.delete();
		nWords = 0;
		ctl.littleEndian <= 1'b1;
		ctl.base[0] <= 32'h1000_4000;
		frame(4, 1'b0);
		wait_done();
		check_img(1'b1, 32'h1000_4000);
		// sink stalled through a capture: words lost, sticky error
		ack(3'b011);
		ctl.irqEnable <= 3'b100;
		stall = 1'b1;
		frame(4, 1'b0);
		chk("bw error", 1, stat.flags[2]);
		chk("irq bw", 1, irq);
		stall = 1'b0;
		wait_done();
		chk("done after drain", 1, stat.flags[0]);
		ack(3'b100);
		chk("bw ack", 0, stat.flags[2]);
		chk("irq off", 0, irq);
		// half resolution with interspersed chroma; on a ramp only the mirrored edges differ
		ack(3'b011);
		got.delete();
		nWords = 0;
		ctl.halfRes <= 1'b1; // width and start column stay multiples of four
		ctl.samplingConventionBit <= 1'b1;
		frame(4, 1'b0);
		wait_done();
		for (int l = 0; l < 2; l++) begin
			logic [7:0] b;
			b = pv(l + 1, 0);
			chk("half luma", {b + 8'h0d, b + 8'h09, b + 8'h05, b + 8'h02}, got[ctl.base[0] + l * ctl.stride[0]]);
			chk("inter u", {16'h0000, b + 8'h09, b}, got[ctl.base[1] + l * ctl.stride[1]]);
			chk("inter v", {16'h0000, b + 8'h0b, b + 8'h02}, got[ctl.base[2] + l * ctl.stride[2]]);
		end
		chk("half count", 6, nWords);
		close_out();
	end
endmodule
